// ---- tcic_regs.vh ----
// Operation
// - Each capture event copies the counter value into the capture register.
// - Low-byte read latches capture high byte into shared temp; high read returns it.
// - Mask bits 5,2,1,0; request needs enable, flag and global enable.
// - Capture flag sets on capture, or on reaching top when capture is top.
// - Timer flags clear on vector execution or on writing one; zero ignored.
// - Compare flags set in the timer cycle after a counter match.
// - A forced compare strobe never sets a compare flag.
// - Overflow flag sets at the counter core's mode-dependent flag-set point.
// - Sync hold mode keeps prescaler clear; leaving it clears prescaler clear.
// - Prescaler clear resets prescaler and self-clears unless sync hold is on.
// - Comparator output state is one when plus input exceeds minus input.
// - Comparator output is synchronised, adding one to two cycles of delay.
// - Comparator off bit 7 switches the comparator off, changeable any time.
// - Comparator flag sets on selected event; clears on vector or written one.
// - Mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// - Comparator-to-capture bit routes synchronised output into capture front end.
// - Comparator interrupt enable bit 3 gates the comparator request.
// - Bit 6 of comparator control reads as zero.
// - Input disable bits turn off pin buffers; port input reads zero.
// - Noise filter needs four equal successive samples before the output changes.
// - Edge select zero captures on falling edges, one on rising edges.
// - When capture register is top, capture input is disconnected.
`ifndef TCIC_REGS_VH
`define TCIC_REGS_VH

`define TCIC_ADDR_DIDR      6'h17
`define TCIC_ADDR_ACTL      6'h1F
`define TCIC_ADDR_CAP_LO    6'h26
`define TCIC_ADDR_CAP_HI    6'h27
`define TCIC_ADDR_FLAGS     6'h2A
`define TCIC_ADDR_MASK      6'h2B
`define TCIC_ADDR_GTC       6'h2F

`define TCIC_RST8           8'h00
`define TCIC_RST16          16'h0000
`define TCIC_MASK_USED      8'h27
`define TCIC_DIDR_USED      4'hF

`define TCIC_B_OVF          0
`define TCIC_B_CMPA         1
`define TCIC_B_CMPB         2
`define TCIC_B_CAP          5
`define TCIC_B_ACMP         4

`define TCIC_B_AC_MODE_LO   0
`define TCIC_B_AC_MODE_HI   1
`define TCIC_B_AC_TOCAP     2
`define TCIC_B_AC_IE        3
`define TCIC_B_AC_OUT       5
`define TCIC_B_AC_OFF       7
`define TCIC_B_PSR          0
`define TCIC_B_TSM          7

`define TCIC_ACM_TOGGLE     2'h0
`define TCIC_ACM_FALL       2'h2
`define TCIC_ACM_RISE       2'h3

`define TCIC_WGM_PFC_ICR    4'h8
`define TCIC_WGM_PC_ICR     4'hA
`define TCIC_WGM_CTC_ICR    4'hC
`define TCIC_WGM_FAST_ICR   4'hE

`define TCIC_FILT_LEN       4

`endif

// ---- tcic_top.v ----
`timescale 1ns/100ps
`include "tcic_regs.vh"

module tcic_top (
    // Clock, reset, enable
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire        ce_i,
    // Register port
    input  wire [5:0]  addr_i,
    input  wire [7:0]  wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [7:0]  rdata_o,
    // Counter core
    input  wire [15:0] counter_value_i,
    input  wire [3:0]  waveform_mode_select_i,
    input  wire        timer_tick_i,
    input  wire        top_reached_i,
    input  wire        overflow_event_i,
    input  wire        compare_a_match_i,
    input  wire        compare_b_match_i,
    input  wire        capture_noise_filter_enable_i,
    input  wire        capture_edge_select_i,
    // Interrupt controller
    input  wire        global_irq_enable_i,
    input  wire [4:0]  irq_ack_i,
    output reg  [4:0]  irq_o,
    // Pins and comparator
    input  wire        capture_pin_i,
    input  wire        comparator_raw_i,
    input  wire        plus_pin_digital_i,
    input  wire        minus_pin_digital_i,
    output reg         plus_pin_read_o,
    output reg         minus_pin_read_o,
    output reg         plus_pin_input_off_o,
    output reg         minus_pin_input_off_o,
    output reg         comparator_off_o,
    output reg         prescaler_reset_o
);

    reg        rst_s1_r;
    reg        rst_n;
    reg [7:0]  timer_interrupt_mask_r;
    reg [7:0]  timer_interrupt_flags_r;
    reg [15:0] capture_value_r;
    reg [7:0]  temp_hi_r;
    reg        sync_hold_mode_r;
    reg        prescaler_clear_r;
    reg        comparator_off_r;
    reg        comparator_flag_r;
    reg        comparator_irq_enable_r;
    reg        comparator_to_capture_r;
    reg [1:0]  comparator_mode_r;
    reg [3:0]  digital_input_disable_r;
    reg        ac_s1_r;
    reg        ac_s2_r;
    reg        ac_prev_r;
    reg        cap_src_r;
    reg [3:0]  filt_hist_r;
    reg        filt_r;
    reg        cap_prev_r;
    reg        cmpa_pend_r;
    reg        cmpb_pend_r;
    reg [7:0]  rd_nxt;
    reg [7:0]  flags_nxt;
    reg        ac_flag_nxt;

    wire       wr_flags = wr_i && (addr_i == `TCIC_ADDR_FLAGS);
    wire       wr_actl  = wr_i && (addr_i == `TCIC_ADDR_ACTL);
    wire       cap_top  = uses_capture_top(waveform_mode_select_i);
    wire       cap_lvl  = capture_noise_filter_enable_i ? filt_r : cap_src_r;
    wire       cap_edge = capture_edge_select_i ? (cap_lvl && !cap_prev_r)
                                                : (!cap_lvl && cap_prev_r);
    wire       cap_evt  = cap_edge && !cap_top;
    wire       ac_rise  = ac_s2_r && !ac_prev_r;
    wire       ac_fall  = !ac_s2_r && ac_prev_r;
    wire [7:0] actl_rd  = {comparator_off_r, 1'b0, ac_s2_r, comparator_flag_r,
                           comparator_irq_enable_r, comparator_to_capture_r,
                           comparator_mode_r};

    // Modes whose top value is held in the capture register
    function uses_capture_top;
        input [3:0] mode;
        begin
            uses_capture_top = (mode == `TCIC_WGM_PFC_ICR) || (mode == `TCIC_WGM_PC_ICR) ||
                               (mode == `TCIC_WGM_CTC_ICR) || (mode == `TCIC_WGM_FAST_ICR);
        end
    endfunction

    // Comparator event selected by the interrupt mode
    function ac_event;
        input [1:0] mode;
        input       rise;
        input       fall;
        begin
            case (mode)
                `TCIC_ACM_TOGGLE: ac_event = rise || fall;
                `TCIC_ACM_FALL:   ac_event = fall;
                `TCIC_ACM_RISE:   ac_event = rise;
                default:          ac_event = 1'b0;
            endcase
        end
    endfunction

    // Reset release is synchronised; assertion stays asynchronous
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // Flag set and clear; a set in the same cycle as a clear wins
    always @* begin
        flags_nxt = timer_interrupt_flags_r;
        if (wr_flags) begin
            flags_nxt = flags_nxt & ~wdata_i;
        end
        flags_nxt[`TCIC_B_OVF]  = flags_nxt[`TCIC_B_OVF] & ~irq_ack_i[`TCIC_B_OVF];
        flags_nxt[`TCIC_B_CMPA] = flags_nxt[`TCIC_B_CMPA] & ~irq_ack_i[`TCIC_B_CMPA];
        flags_nxt[`TCIC_B_CMPB] = flags_nxt[`TCIC_B_CMPB] & ~irq_ack_i[`TCIC_B_CMPB];
        flags_nxt[`TCIC_B_CAP]  = flags_nxt[`TCIC_B_CAP] & ~irq_ack_i[3];
        if (overflow_event_i) begin
            flags_nxt[`TCIC_B_OVF] = 1'b1;
        end
        // Only true matches reach here; a forced strobe has no path in
        if (timer_tick_i && cmpa_pend_r) begin
            flags_nxt[`TCIC_B_CMPA] = 1'b1;
        end
        if (timer_tick_i && cmpb_pend_r) begin
            flags_nxt[`TCIC_B_CMPB] = 1'b1;
        end
        if (cap_top ? top_reached_i : cap_evt) begin
            flags_nxt[`TCIC_B_CAP] = 1'b1;
        end
        flags_nxt = flags_nxt & `TCIC_MASK_USED;
        ac_flag_nxt = comparator_flag_r;
        if ((wr_actl && wdata_i[`TCIC_B_ACMP]) || irq_ack_i[4]) begin
            ac_flag_nxt = 1'b0;
        end
        if (ac_event(comparator_mode_r, ac_rise, ac_fall)) begin
            ac_flag_nxt = 1'b1;
        end
    end

    // Read mux
    always @* begin
        case (addr_i)
            `TCIC_ADDR_DIDR:   rd_nxt = {4'h0, digital_input_disable_r};
            `TCIC_ADDR_ACTL:   rd_nxt = actl_rd;
            `TCIC_ADDR_CAP_LO: rd_nxt = capture_value_r[7:0];
            `TCIC_ADDR_CAP_HI: rd_nxt = temp_hi_r;
            `TCIC_ADDR_FLAGS:  rd_nxt = timer_interrupt_flags_r;
            `TCIC_ADDR_MASK:   rd_nxt = timer_interrupt_mask_r;
            `TCIC_ADDR_GTC:    rd_nxt = {sync_hold_mode_r, 6'h00, prescaler_clear_r};
            default:           rd_nxt = `TCIC_RST8;
        endcase
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o                 <= `TCIC_RST8;
            irq_o                   <= 5'h00;
            plus_pin_read_o         <= 1'b0;
            minus_pin_read_o        <= 1'b0;
            plus_pin_input_off_o    <= 1'b0;
            minus_pin_input_off_o   <= 1'b0;
            comparator_off_o        <= 1'b0;
            prescaler_reset_o       <= 1'b0;
            timer_interrupt_mask_r  <= `TCIC_RST8;
            timer_interrupt_flags_r <= `TCIC_RST8;
            capture_value_r         <= `TCIC_RST16;
            temp_hi_r               <= `TCIC_RST8;
            sync_hold_mode_r        <= 1'b0;
            prescaler_clear_r       <= 1'b0;
            comparator_off_r        <= 1'b0;
            comparator_flag_r       <= 1'b0;
            comparator_irq_enable_r <= 1'b0;
            comparator_to_capture_r <= 1'b0;
            comparator_mode_r       <= 2'h0;
            digital_input_disable_r <= 4'h0;
            ac_s1_r                 <= 1'b0;
            ac_s2_r                 <= 1'b0;
            ac_prev_r               <= 1'b0;
            cap_src_r               <= 1'b0;
            filt_hist_r             <= 4'h0;
            filt_r                  <= 1'b0;
            cap_prev_r              <= 1'b0;
            cmpa_pend_r             <= 1'b0;
            cmpb_pend_r             <= 1'b0;
        end else if (ce_i) begin
            rdata_o <= rd_i ? rd_nxt : `TCIC_RST8;

            // Comparator output synchroniser; off forces a quiet low level
            ac_s1_r   <= comparator_raw_i && !comparator_off_r;
            ac_s2_r   <= ac_s1_r;
            ac_prev_r <= ac_s2_r;

            // Capture front end, pin or comparator
            cap_src_r   <= comparator_to_capture_r ? ac_s2_r : capture_pin_i;
            filt_hist_r <= {filt_hist_r[`TCIC_FILT_LEN-2:0], cap_src_r};
            if (filt_hist_r == 4'hF) begin
                filt_r <= 1'b1;
            end else if (filt_hist_r == 4'h0) begin
                filt_r <= 1'b0;
            end
            cap_prev_r <= cap_lvl;

            // Compare matches wait for the next timer tick
            if (compare_a_match_i) begin
                cmpa_pend_r <= 1'b1;
            end else if (timer_tick_i) begin
                cmpa_pend_r <= 1'b0;
            end
            if (compare_b_match_i) begin
                cmpb_pend_r <= 1'b1;
            end else if (timer_tick_i) begin
                cmpb_pend_r <= 1'b0;
            end

            timer_interrupt_flags_r <= flags_nxt;
            comparator_flag_r       <= ac_flag_nxt;

            // Capture register: event load, or software write via temp
            if (cap_evt) begin
                capture_value_r <= counter_value_i;
            end else if (wr_i && addr_i == `TCIC_ADDR_CAP_LO) begin
                capture_value_r <= {temp_hi_r, wdata_i};
            end
            if (wr_i && addr_i == `TCIC_ADDR_CAP_HI) begin
                temp_hi_r <= wdata_i;
            end else if (rd_i && addr_i == `TCIC_ADDR_CAP_LO) begin
                temp_hi_r <= capture_value_r[15:8];
            end

            if (wr_i && addr_i == `TCIC_ADDR_MASK) begin
                timer_interrupt_mask_r <= wdata_i & `TCIC_MASK_USED;
            end
            if (wr_i && addr_i == `TCIC_ADDR_DIDR) begin
                digital_input_disable_r <= wdata_i[3:0] & `TCIC_DIDR_USED;
            end

            // Prescaler clear holds only while sync hold is set
            if (wr_i && addr_i == `TCIC_ADDR_GTC) begin
                sync_hold_mode_r  <= wdata_i[`TCIC_B_TSM];
                prescaler_clear_r <= wdata_i[`TCIC_B_PSR];
            end else if (!sync_hold_mode_r) begin
                prescaler_clear_r <= 1'b0;
            end

            if (wr_actl) begin
                comparator_off_r        <= wdata_i[`TCIC_B_AC_OFF];
                comparator_irq_enable_r <= wdata_i[`TCIC_B_AC_IE];
                comparator_to_capture_r <= wdata_i[`TCIC_B_AC_TOCAP];
                comparator_mode_r       <= wdata_i[`TCIC_B_AC_MODE_HI:`TCIC_B_AC_MODE_LO];
            end

            // Requests; index 3 carries capture, 4 the comparator
            irq_o[0] <= global_irq_enable_i && timer_interrupt_mask_r[0] &&
                        timer_interrupt_flags_r[0];
            irq_o[1] <= global_irq_enable_i && timer_interrupt_mask_r[1] &&
                        timer_interrupt_flags_r[1];
            irq_o[2] <= global_irq_enable_i && timer_interrupt_mask_r[2] &&
                        timer_interrupt_flags_r[2];
            irq_o[3] <= global_irq_enable_i && timer_interrupt_mask_r[`TCIC_B_CAP] &&
                        timer_interrupt_flags_r[`TCIC_B_CAP];
            irq_o[4] <= global_irq_enable_i && comparator_irq_enable_r &&
                        comparator_flag_r;

            prescaler_reset_o     <= prescaler_clear_r;
            comparator_off_o      <= comparator_off_r;
            plus_pin_input_off_o  <= digital_input_disable_r[0];
            minus_pin_input_off_o <= digital_input_disable_r[1];
            plus_pin_read_o       <= plus_pin_digital_i && !digital_input_disable_r[0];
            minus_pin_read_o      <= minus_pin_digital_i && !digital_input_disable_r[1];
        end
    end

endmodule

// ---- tcic_partner.sv ----
`timescale 1ns/100ps
module tcic_partner #(
    parameter DLY = 1
) (
    // Clock
    input  wire  clk_i,
    // Requested levels
    input  wire  pin_req_i,
    input  wire  cmp_req_i,
    // Lines to the block
    output logic capture_pin_o,
    output logic comparator_raw_o
);
    logic [7:0] pin_q = 8'h00;
    logic [7:0] cmp_q = 8'h00;
    initial begin
        capture_pin_o = 1'b0;
        comparator_raw_o = 1'b0;
    end
    always @(posedge clk_i) begin
        pin_q <= {pin_q[6:0], pin_req_i};
        cmp_q <= {cmp_q[6:0], cmp_req_i};
        capture_pin_o <= pin_q[DLY];
        // Raw output is asynchronous, so it moves off the edge to stress the synchroniser
        comparator_raw_o <= #3 cmp_q[DLY];
    end
endmodule

// ---- tcic_top_properties.sv ----
`timescale 1ns/100ps
module tcic_top_properties (
    // Clock and reset
    input wire       clk_i,
    input wire       rstn_i,
    input wire       ce_i,
    // Register port
    input wire [5:0] addr_i,
    input wire [7:0] wdata_i,
    input wire       wr_i,
    input wire       rd_i,
    input wire [7:0] rdata_o,
    // Interrupts
    input wire       global_irq_enable_i,
    input wire       overflow_event_i,
    input wire [4:0] irq_ack_i,
    input wire [4:0] irq_o,
    // Pins
    input wire       plus_pin_digital_i,
    input wire       plus_pin_read_o,
    input wire       plus_pin_input_off_o,
    input wire       comparator_off_o,
    input wire       prescaler_reset_o
);
    // Mirrors the two-flop reset release so checks start with the design
    reg  [1:0] run_r;
    wire       wr_gtc;
    assign wr_gtc = ce_i && wr_i && (addr_i == 6'h2F);
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) run_r <= 2'b00;
        else run_r <= {run_r[0], 1'b1};
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!run_r[1]);
    chk_ac_reserved: assert property (ce_i && rd_i && addr_i == 6'h1F |=> !rdata_o[6])
        else $error("reserved comparator bit read as one");
    chk_irq_global: assert property (ce_i && !global_irq_enable_i |=> irq_o == 5'h00)
        else $error("request without global enable");
    chk_irq_ack: assert property (ce_i && irq_ack_i[0] && !overflow_event_i ##1
        !overflow_event_i |=> !irq_o[0]) else $error("overflow request kept after ack");
    chk_psr_pulse: assert property (wr_gtc && wdata_i == 8'h01 |=>
        ##[1:2] (prescaler_reset_o ##1 !prescaler_reset_o)) else $error("no clear pulse");
    chk_psr_hold: assert property (prescaler_reset_o && $past(prescaler_reset_o) && !wr_gtc
        && !$past(wr_gtc) && !$past(wr_gtc, 2) |=> prescaler_reset_o)
        else $error("held clear dropped");
    chk_psr_release: assert property (wr_gtc && wdata_i == 8'h00
        |=> ##[1:2] !prescaler_reset_o) else $error("clear kept after hold off");
    chk_pin_off: assert property (plus_pin_input_off_o && $past(plus_pin_input_off_o)
        |-> !plus_pin_read_o) else $error("disabled pin reads one");
    chk_pin_follow: assert property (ce_i && !plus_pin_input_off_o && !(wr_i &&
        addr_i == 6'h17) && !$past(wr_i && addr_i == 6'h17)
        |=> plus_pin_read_o == $past(plus_pin_digital_i))
        else $error("pin read does not follow pin");
    chk_ac_off: assert property (ce_i && wr_i && addr_i == 6'h1F && wdata_i[7]
        |=> ##[1:2] comparator_off_o) else $error("comparator not switched off");
endmodule
bind tcic_top tcic_top_properties tcic_top_properties_i (.clk_i, .rstn_i, .ce_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .global_irq_enable_i, .overflow_event_i, .irq_ack_i,
    .irq_o, .plus_pin_digital_i, .plus_pin_read_o, .plus_pin_input_off_o, .comparator_off_o,
    .prescaler_reset_o);

// ---- test_tcic_top.sv ----
`timescale 1ns/100ps
module test_tcic_top;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        gie = 1'b0;
    logic        nf = 1'b0;
    logic        es = 1'b0;
    logic        pin_req = 1'b0;
    logic        cmp_req = 1'b0;
    logic [1:0]  pins = 2'b00;
    logic [5:0]  addr_i = 6'h00;
    logic [7:0]  wdata_i = 8'h00;
    logic [4:0]  ev = 5'h00;
    logic [4:0]  ack = 5'h00;
    logic [3:0]  wm = 4'h0;
    logic [15:0] cnt = 16'h0000;
    wire  [7:0]  rdata_o;
    wire  [4:0]  irq_o;
    wire         cap_pin, cmp_raw, p_rd, m_rd, prs, p_off, m_off, c_off;
    int          bad_count = 0;
    int          comparisons = 0;
    int          j;
    logic [5:0]  am [8] = '{6'h17, 6'h1F, 6'h2B, 6'h2F, 6'h2A, 6'h26, 6'h27, 6'h3F};
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    tcic_top tcic_top_i (.clk_i, .rstn_i, .ce_i(1'b1), .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .counter_value_i(cnt), .waveform_mode_select_i(wm), .timer_tick_i(ev[4]),
        .top_reached_i(ev[3]), .overflow_event_i(ev[0]), .compare_a_match_i(ev[1]),
        .compare_b_match_i(ev[2]), .capture_noise_filter_enable_i(nf),
        .capture_edge_select_i(es), .global_irq_enable_i(gie), .irq_ack_i(ack), .irq_o,
        .capture_pin_i(cap_pin), .comparator_raw_i(cmp_raw), .plus_pin_digital_i(pins[0]),
        .minus_pin_digital_i(pins[1]), .plus_pin_read_o(p_rd), .minus_pin_read_o(m_rd),
        .plus_pin_input_off_o(p_off), .minus_pin_input_off_o(m_off), .comparator_off_o(c_off),
        .prescaler_reset_o(prs));
    tcic_partner #(.DLY(2)) tcic_partner_i (.clk_i, .pin_req_i(pin_req), .cmp_req_i(cmp_req),
        .capture_pin_o(cap_pin), .comparator_raw_o(cmp_raw));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic ck(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rc(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 ck(rdata_o, e);
    endtask
    task automatic pulse(input logic [4:0] m, input logic [4:0] k);
        @(posedge clk_i);
        ev <= m;
        ack <= k;
        @(posedge clk_i);
        ev <= 5'h00;
        ack <= 5'h00;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        bad_count++;
        give_verdict;
    end
    initial begin
        cyc(16);
        rstn_i <= 1'b1;
        cyc(3);
        for (j = 0; j < 8; j++) rc(am[j], 8'h00);
        $display("reset values done");
        wr(6'h2B, 8'h27);
        rc(6'h2B, 8'h27);
        @(posedge clk_i) gie <= 1'b1;
        pulse(5'h01, 5'h00);
        rc(6'h2A, 8'h01);
        ck({3'b000, irq_o}, 8'h01);
        @(posedge clk_i) gie <= 1'b0;
        cyc(3);
        ck({3'b000, irq_o}, 8'h00);
        @(posedge clk_i) gie <= 1'b1;
        cyc(3);
        ck({3'b000, irq_o}, 8'h01);
        pulse(5'h00, 5'h01);
        rc(6'h2A, 8'h00);
        ck({3'b000, irq_o}, 8'h00);
        pulse(5'h01, 5'h00);
        wr(6'h2A, 8'h00);
        rc(6'h2A, 8'h01);
        wr(6'h2A, 8'h01);
        rc(6'h2A, 8'h00);
        for (j = 1; j < 3; j++) begin
            pulse(5'h01 << j, 5'h00);
            rc(6'h2A, 8'h00);
            pulse(5'h10, 5'h00);
            rc(6'h2A, 8'h01 << j);
            ck({3'b000, irq_o}, 8'h01 << j);
            wr(6'h2A, 8'h01 << j);
        end
        $display("timer flags done");
        @(posedge clk_i) es <= 1'b1;
        cnt <= 16'hA5C3;
        pin_req <= 1'b1;
        cyc(10);
        rc(6'h2A, 8'h20);
        rc(6'h26, 8'hC3);
        @(posedge clk_i) cnt <= 16'h1234;
        es <= 1'b0;
        pin_req <= 1'b0;
        cyc(10);
        rc(6'h27, 8'hA5);
        rc(6'h26, 8'h34);
        rc(6'h27, 8'h12);
        wr(6'h2A, 8'h20);
        @(posedge clk_i) es <= 1'b1;
        wm <= 4'hC;
        pin_req <= 1'b1;
        cyc(10);
        rc(6'h2A, 8'h00);
        pulse(5'h08, 5'h00);
        rc(6'h2A, 8'h20);
        rc(6'h26, 8'h34);
        wr(6'h2A, 8'h20);
        @(posedge clk_i) wm <= 4'h0;
        nf <= 1'b1;
        es <= 1'b0;
        cyc(8);
        pin_req <= 1'b0;
        cyc(3);
        pin_req <= 1'b1;
        cyc(12);
        rc(6'h2A, 8'h00);
        @(posedge clk_i) pin_req <= 1'b0;
        cyc(12);
        rc(6'h2A, 8'h20);
        wr(6'h2A, 8'h20);
        $display("capture done");
        for (j = 0; j < 4; j++) begin
            wr(6'h1F, 8'h10 | j[1:0]);
            @(posedge clk_i) cmp_req <= 1'b1;
            cyc(8);
            rc(6'h1F, 8'h20 | j[1:0] | ((j == 0 || j == 3) ? 8'h10 : 8'h00));
            wr(6'h1F, 8'h10 | j[1:0]);
            @(posedge clk_i) cmp_req <= 1'b0;
            cyc(8);
            rc(6'h1F, j[1:0] | ((j == 0 || j == 2) ? 8'h10 : 8'h00));
        end
        wr(6'h1F, 8'h0B);
        @(posedge clk_i) cmp_req <= 1'b1;
        cyc(9);
        ck({3'b000, irq_o}, 8'h10);
        pulse(5'h00, 5'h10);
        rc(6'h1F, 8'h2B);
        wr(6'h1F, 8'h03);
        wr(6'h1F, 8'h07);
        @(posedge clk_i) cnt <= 16'h0F0F;
        cmp_req <= 1'b0;
        cyc(14);
        rc(6'h2A, 8'h20);
        rc(6'h26, 8'h0F);
        wr(6'h1F, 8'h80);
        rc(6'h1F, 8'h80);
        ck({5'h00, c_off, m_off, p_off}, 8'h04);
        $display("comparator done");
        @(posedge clk_i) pins <= 2'b11;
        wr(6'h17, 8'h03);
        rc(6'h17, 8'h03);
        ck({6'h00, m_rd, p_rd}, 8'h00);
        ck({5'h00, c_off, m_off, p_off}, 8'h07);
        wr(6'h17, 8'h00);
        cyc(2);
        ck({6'h00, m_rd, p_rd}, 8'h03);
        ck({5'h00, c_off, m_off, p_off}, 8'h04);
        wr(6'h2F, 8'h81);
        cyc(3);
        ck({7'h00, prs}, 8'h01);
        wr(6'h2F, 8'h00);
        cyc(3);
        ck({7'h00, prs}, 8'h00);
        wr(6'h2F, 8'h01);
        cyc(4);
        ck({7'h00, prs}, 8'h00);
        $display("pins and prescaler done");
        give_verdict;
    end
endmodule
